// ---- logic/sarp_read_port.sv ----
// Top of the converter digital side: start, busy and result read port

// What this block does
// - Start strobe accepted asynchronously, low active
// - Sample and convert on start rising edge
// - Busy low throughout conversion, high when done
// - Chip select plus read drives latch out
// - Word variant gives sixteen bits at once
// - Byte variant gives eight bits per read
// - Host byte select picks result half
// - Result coded as twos complement
// - Zero input sits between zeros and ones
// - Top code is zero then all ones
// - Bottom code is one then all zeros
module sarp_read_port
    import sarp_pkg::*;
#(
    parameter bit BYTE_MODE = 1'b0,
    parameter int CONV_CNT = CONV_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic convert_start_n,
    input wire logic chip_sel_n,
    input wire logic read_n,
    input wire logic upper_byte_select,
    input wire logic [RESULT_W-1:0] sample_in,
    output logic busy_n,
    output logic [RESULT_W-1:0] result_word_out,
    output logic [RESULT_W-1:0] result_word_oe,
    output logic [BYTE_W-1:0] result_byte_out,
    output logic [BYTE_W-1:0] result_byte_oe
);
    // Refuse counts the counter cannot hold, and halves that do not tile the word
    if (CONV_CNT < 2 || CONV_CNT >= (1 << CNT_W))
    begin : g_bad_conv_cnt
        $error("CONV_CNT out of range");
    end
    if (RESULT_W != 2 * BYTE_W)
    begin : g_bad_byte_split
        $error("result word must be two bytes");
    end

    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CNT - 1);
    localparam logic [CNT_W-1:0] CONV_LEN = CNT_W'(CONV_CNT);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    // Idle pin levels: strobes high, byte select low
    localparam logic START_IDLE = 1'b1;
    localparam sarp_rd_s RD_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, upper: 1'b0};

    logic start_s;
    sarp_rd_s rd_s;
    logic start_d_r;
    sarp_state_e state_r;
    sarp_state_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [RESULT_W-1:0] held_r;
    logic [RESULT_W-1:0] latch_r;
    logic [RESULT_W-1:0] latch_nxt;
    logic [CNT_W-1:0] busy_len_r;

    // Start and read strobe pins cross into the core clock before any logic looks at them; sample_in is taken directly
    sarp_sync #(.W(1), .INIT(START_IDLE)) u_start_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .d(convert_start_n),
        .q(start_s)
    );
    sarp_sync #(.W($bits(sarp_rd_s)), .INIT(RD_IDLE)) u_rd_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .d({chip_sel_n, read_n, upper_byte_select}),
        .q(rd_s)
    );

    // Rising edge of the start strobe; falling edge does nothing
    wire start_rise = start_s & ~start_d_r;
    wire conv_done = (state_r == SARP_CONV) && (cnt_r == CONV_LAST);
    // Output drive gate: both strobes low
    wire read_en = ~rd_s.cs_n & ~rd_s.rd_n;

    // A new start during conversion is ignored, the old sample stands
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        latch_nxt = latch_r;
        case (state_r)
            SARP_IDLE:
            begin
                if (start_rise)
                begin
                    state_nxt = SARP_CONV;
                    cnt_nxt = CNT_ZERO;
                end
            end
            SARP_CONV:
            begin
                cnt_nxt = cnt_r + CNT_ONE;
                if (conv_done)
                begin
                    state_nxt = SARP_IDLE;
                    latch_nxt = held_r;
                end
            end
            default:
            begin
                state_nxt = SARP_IDLE;
            end
        endcase
    end

    // Sample is frozen on the accepted edge; the code is passed as
    // twos complement, so full scale and midscale codes keep their bits
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            start_d_r <= START_IDLE;
            state_r <= SARP_IDLE;
            cnt_r <= CNT_ZERO;
            held_r <= RESULT_RST;
            latch_r <= RESULT_RST;
        end
        else
        begin
            start_d_r <= start_s;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (start_rise && state_r == SARP_IDLE)
                held_r <= sample_in;
            latch_r <= latch_nxt;
        end
    end

    // Selection of what goes to the pins
    wire [BYTE_W-1:0] byte_sel = rd_s.upper ? latch_nxt[RESULT_W-1:BYTE_W]
                                            : latch_nxt[BYTE_W-1:0];
    wire word_en = read_en & ~BYTE_MODE;
    wire byte_en = read_en & BYTE_MODE;

    // Registered pin drivers; latch_nxt so data is valid as busy rises
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            busy_n <= 1'b1;
            result_word_out <= RESULT_RST;
            result_word_oe <= '0;
            result_byte_out <= '0;
            result_byte_oe <= '0;
        end
        else
        begin
            busy_n <= (state_nxt != SARP_CONV);
            result_word_out <= latch_nxt;
            result_word_oe <= {RESULT_W{word_en}};
            result_byte_out <= byte_sel;
            result_byte_oe <= {BYTE_W{byte_en}};
        end
    end

    // Busy length for the checks, counted apart from the conversion
    // counter so that a slip there cannot hide itself
    always_ff @(posedge core_clk)
    begin
        if (!rstn || busy_n)
        begin
            busy_len_r <= CNT_ZERO;
        end
        else
        begin
            busy_len_r <= busy_len_r + CNT_ONE;
        end
    end

    // Checks
    a_busy_on_start: assert property (@(posedge core_clk) disable iff (!rstn)
        (start_rise && state_r == SARP_IDLE) |=> !busy_n)
        else $error("busy not low after start");
    a_busy_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(busy_n) |-> busy_len_r == CONV_LEN)
        else $error("busy length wrong");
    a_busy_release: assert property (@(posedge core_clk) disable iff (!rstn)
        $fell(busy_n) |-> ##[1:300] busy_n)
        else $error("busy never released");
    a_fall_ignored: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_r == SARP_IDLE && !start_rise) |=> state_r == SARP_IDLE)
        else $error("conversion without rising edge");
    a_start_refused: assert property (@(posedge core_clk) disable iff (!rstn)
        (start_rise && state_r == SARP_CONV && !conv_done) |=> ($stable(held_r) && !busy_n))
        else $error("start taken while busy");
    a_word_drive: assert property (@(posedge core_clk) disable iff (!rstn)
        (word_en) |=> (result_word_oe == '1 && result_word_out == latch_r))
        else $error("word not driven on read");
    a_float_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        (!read_en) |=> (result_word_oe == '0 && result_byte_oe == '0))
        else $error("bus driven outside read");
    a_upper_byte: assert property (@(posedge core_clk) disable iff (!rstn)
        (byte_en && rd_s.upper) |=> result_byte_out == latch_r[RESULT_W-1:BYTE_W])
        else $error("upper byte wrong");
    a_lower_byte: assert property (@(posedge core_clk) disable iff (!rstn)
        (byte_en && !rd_s.upper) |=> result_byte_out == latch_r[BYTE_W-1:0])
        else $error("lower byte wrong");
    a_latch_code: assert property (@(posedge core_clk) disable iff (!rstn)
        conv_done |=> latch_r == $past(held_r))
        else $error("latch lost result code");

    c_conversion: cover property (@(posedge core_clk) disable iff (!rstn)
        $rose(busy_n));
    c_word_read: cover property (@(posedge core_clk) disable iff (!rstn)
        word_en && busy_n);
    c_byte_pair: cover property (@(posedge core_clk) disable iff (!rstn)
        (byte_en && rd_s.upper) ##[1:20] (byte_en && !rd_s.upper));
    c_full_scale: cover property (@(posedge core_clk) disable iff (!rstn)
        conv_done && (held_r == CODE_POS_MAX || held_r == CODE_NEG_MAX));
    c_start_ignored: cover property (@(posedge core_clk) disable iff (!rstn)
        start_rise && state_r == SARP_CONV);
endmodule : sarp_read_port

// ---- logic/sarp_pkg.sv ----
// Package with constants and carrier types for the converter read port
package sarp_pkg;
    localparam int RESULT_W = 16;
    localparam int BYTE_W = 8;
    // Conversion time as a longest figure, rounded down to cycles
    localparam int CONV_TIME_NS = 5300;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    // Busy low delay after start, longest figure
    localparam int BUSY_DELAY_NS = 100;
    localparam int BUSY_DELAY_CYCLES = BUSY_DELAY_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
    localparam logic [RESULT_W-1:0] CODE_POS_MAX = 16'h7fff;
    localparam logic [RESULT_W-1:0] CODE_NEG_MAX = 16'h8000;

    typedef enum logic [0:0]
    {
        SARP_IDLE = 1'b0,
        SARP_CONV = 1'b1
    } sarp_state_e;

    // Host read strobes, already synchronised
    typedef struct packed
    {
        logic cs_n;
        logic rd_n;
        logic upper;
    } sarp_rd_s;
endpackage : sarp_pkg

// ---- logic/sarp_sync.sv ----
// Two-stage synchroniser for a bundle of pin inputs
module sarp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            meta_r <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sarp_sync

// ---- test/sarp_host.sv ----
// Host model: starts conversions and drives the read strobes
module sarp_host
    import sarp_pkg::*;
(
    input wire logic core_clk,
    input wire logic busy_n,
    output logic convert_start_n,
    output logic chip_sel_n,
    output logic read_n,
    output logic upper_byte_select,
    output logic [RESULT_W-1:0] sample_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle pins at time zero
    initial
    begin
        convert_start_n = 1'b1;
        chip_sel_n = 1'b1;
        read_n = 1'b1;
        upper_byte_select = 1'b0;
        sample_in = '0;
    end
    // Three-cycle low pulse so the synchroniser surely sees it; the
    // sample only settles at the rise, so freezing it early shows
    task automatic start(input logic [RESULT_W-1:0] code);
        @(posedge core_clk);
        sample_in <= ~code;
        convert_start_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        convert_start_n <= 1'b1;
        sample_in <= code;
        while (busy_n !== 1'b0) @(posedge core_clk);
        sample_in <= ~code; // Input moves on once held
    endtask : start
    // Select and read together; may be left low for good
    task automatic bus(input logic on, input logic up);
        @(posedge core_clk);
        chip_sel_n <= ~on;
        read_n <= ~on;
        upper_byte_select <= up;
    endtask : bus
    // Two-cycle start pulse meant to land inside a running conversion
    task automatic kick(input logic [RESULT_W-1:0] code);
        @(posedge core_clk);
        sample_in <= code;
        convert_start_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        convert_start_n <= 1'b1;
    endtask : kick
    // Select and read driven apart, for the half-asserted cases
    task automatic strobes(input logic cs_on, input logic rd_on);
        @(posedge core_clk);
        chip_sel_n <= ~cs_on;
        read_n <= ~rd_on;
    endtask : strobes
endmodule : sarp_host

// ---- test/sarp_read_port_tb.sv ----
// Bench: word and byte variants fed from one host
module sarp_read_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sarp_pkg::*;
    // Short conversion, yet long enough for a second start to land inside it
    localparam int CONV = 10;
    localparam logic [RESULT_W-1:0] CODES [6] =
        '{16'h7fff, 16'h7ffe, 16'h0000, 16'hffff, 16'h8000, 16'h8001};
    logic core_clk, rstn, cs_n, rd_n, start_n, up, busy_n;
    logic [RESULT_W-1:0] sample, word_out, word_oe, b_word_oe;
    logic [BYTE_W-1:0] byte_out, byte_oe, w_byte_oe;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    sarp_host u_host (.core_clk(core_clk), .busy_n(busy_n), .convert_start_n(start_n),
        .chip_sel_n(cs_n), .read_n(rd_n), .upper_byte_select(up), .sample_in(sample));
    sarp_read_port #(.BYTE_MODE(1'b0), .CONV_CNT(CONV)) dut (.core_clk(core_clk),
        .rstn(rstn), .convert_start_n(start_n), .chip_sel_n(cs_n), .read_n(rd_n),
        .upper_byte_select(up), .sample_in(sample), .busy_n(busy_n),
        .result_word_out(word_out), .result_word_oe(word_oe), .result_byte_out(),
        .result_byte_oe(w_byte_oe));
    sarp_read_port #(.BYTE_MODE(1'b1), .CONV_CNT(CONV)) dut_b (.core_clk(core_clk),
        .rstn(rstn), .convert_start_n(start_n), .chip_sel_n(cs_n), .read_n(rd_n),
        .upper_byte_select(up), .sample_in(sample), .busy_n(), .result_word_out(),
        .result_word_oe(b_word_oe), .result_byte_out(byte_out), .result_byte_oe(byte_oe));
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic results;
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    // Busy length counted in edges; result must land as busy rises;
    // with again set, a start pulse mid-conversion must change nothing
    task automatic convert(input logic [RESULT_W-1:0] code, input logic again = 1'b0);
        int n;
        n = 0;
        u_host.start(code);
        if (again)
        begin
            fork
                u_host.kick(~code);
            join_none
        end
        while (busy_n === 1'b0 && n < 100)
        begin
            @(posedge core_clk);
            n++;
        end
        #1;
        check(n == CONV, "busy length");
        check(word_out === code, "word result");
        check(word_oe === 16'hffff, "word driven");
    endtask : convert
    // Both halves of the last result through the byte variant
    task automatic byte_read(input logic [RESULT_W-1:0] code);
        u_host.bus(1'b1, 1'b1);
        repeat (4) @(posedge core_clk);
        #1;
        check(byte_out === code[15:8] && byte_oe === 8'hff, "upper byte");
        u_host.bus(1'b1, 1'b0);
        repeat (4) @(posedge core_clk);
        #1;
        check(byte_out === code[7:0], "lower byte");
    endtask : byte_read
    // Bus must float once either strobe ends; unused groups never drive
    task automatic release_bus;
        u_host.strobes(1'b1, 1'b0);
        repeat (4) @(posedge core_clk);
        #1;
        check(word_oe === '0 && byte_oe === '0, "read strobe high");
        u_host.strobes(1'b0, 1'b1);
        repeat (4) @(posedge core_clk);
        #1;
        check(word_oe === '0 && byte_oe === '0, "select high");
        u_host.bus(1'b0, 1'b0);
        repeat (4) @(posedge core_clk);
        #1;
        check(word_oe === '0 && byte_oe === '0, "bus released");
        check(b_word_oe === '0 && w_byte_oe === '0, "unused group");
    endtask : release_bus
    // Extreme and midscale codes, then byte reads and release
    initial
    begin
        rstn = 1'b0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1;
        check(busy_n === 1'b1 && word_out === RESULT_RST, "reset state");
        u_host.bus(1'b1, 1'b0);
        convert(16'h0001, 1'b1);
        for (int i = 0; i < $size(CODES); i++)
            convert(CODES[i]);
        byte_read(CODES[5]);
        release_bus();
        results();
    end
    // Hang guard, well beyond the fewer than two hundred cycles needed
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            results();
        end
    end
endmodule : sarp_read_port_tb
